// File: hw/dcc_channels.sv
// DMA channel registers, arbiter and transfer sequencer.
module dcc_channels #(
  parameter int NCH = 7
) (
  // Clock and reset.
  input wire logic clock,
  input wire logic srst,
  // Register port.
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Peripheral requests and acknowledges.
  input wire logic [NCH-1:0] periph_req,
  output logic [NCH-1:0] periph_ack,
  // System bus master.
  output logic bus_req,
  output logic bus_we,
  output logic [31:0] bus_addr,
  output logic [1:0] bus_size,
  output logic [31:0] bus_wdata,
  input wire logic bus_ready,
  input wire logic bus_err,
  input wire logic [31:0] bus_rdata,
  // Per-channel interrupt pulses.
  output logic [NCH-1:0] irq
);
  localparam int CW = (NCH > 1) ? $clog2(NCH) : 1;

  logic [14:0] ctl_r [NCH];
  logic [15:0] cnt_r [NCH];
  logic [15:0] reload_r [NCH];
  logic [31:0] pbase_r [NCH];
  logic [31:0] mbase_r [NCH];
  logic [31:0] pptr_r [NCH];
  logic [31:0] mptr_r [NCH];
  logic [3*NCH-1:0] flags_r;
  dcc_pkg::dcc_state_t state_r;
  logic [CW-1:0] cur_r;
  logic [31:0] data_r;
  logic [31:0] bus_addr_r;
  logic [31:0] reg_rdata_r;
  logic [NCH-1:0] irq_r;
  logic bus_we_r;
  logic [1:0] bus_size_r;

  // One-hot channel match for a register offset, shared by the four per-channel register decoders.
  function automatic logic [NCH-1:0] hit_fn(input logic [7:0] a, input logic [7:0] ofs);
    hit_fn = '0;
    for (int c = 0; c < NCH; c++)
    begin
      hit_fn[c] = (a == 8'(ofs + 8'(8'(c) * dcc_pkg::CH_STRIDE)));
    end
  endfunction

  // Drops the low address bits that the access width makes meaningless.
  function automatic logic [31:0] align_fn(input logic [31:0] a, input logic [1:0] w);
    align_fn = a;
    if (w == dcc_pkg::W16)
    begin
      align_fn[0] = 1'b0;
    end
    else if (w == dcc_pkg::W32)
    begin
      align_fn[1:0] = 2'b00;
    end
  endfunction

  // Address step in bytes for a width code.
  function automatic logic [31:0] step_fn(input logic [1:0] w);
    step_fn = (w == dcc_pkg::W32) ? 32'h4 : ((w == dcc_pkg::W16) ? 32'h2 : 32'h1);
  endfunction

  logic [NCH-1:0] hit_ctl;
  logic [NCH-1:0] hit_cnt;
  logic [NCH-1:0] hit_pb;
  logic [NCH-1:0] hit_mb;
  assign hit_ctl = hit_fn(reg_addr, dcc_pkg::CTL_OFS);
  assign hit_cnt = hit_fn(reg_addr, dcc_pkg::CNT_OFS);
  assign hit_pb = hit_fn(reg_addr, dcc_pkg::PBASE_OFS);
  assign hit_mb = hit_fn(reg_addr, dcc_pkg::MBASE_OFS);

  // Eligible channels and the arbiter. Strict greater-than keeps the lowest number on a tie.
  logic [NCH-1:0] elig;
  logic found;
  logic [CW-1:0] win;
  logic [1:0] best;
  always_comb
  begin
    found = 1'b0;
    win = '0;
    best = 2'b00;
    for (int c = 0; c < NCH; c++)
    begin
      elig[c] = ctl_r[c][dcc_pkg::ON_BIT] && (cnt_r[c] != 16'h0000)
        && (ctl_r[c][dcc_pkg::M2M_BIT] || periph_req[c]);
      if (elig[c] && (!found || ctl_r[c][dcc_pkg::CHAN_PRIORITY_LSB +: 2] > best))
      begin
        found = 1'b1;
        win = CW'(c);
        best = ctl_r[c][dcc_pkg::CHAN_PRIORITY_LSB +: 2];
      end
    end
  end

  // Source and destination addresses of the winner, aligned to their own widths.
  logic [14:0] wctl;
  logic [31:0] w_pa;
  logic [31:0] w_ma;
  logic [14:0] cctl;
  logic [31:0] c_pa;
  logic [31:0] c_ma;
  assign wctl = ctl_r[win];
  assign cctl = ctl_r[cur_r];
  assign w_pa = align_fn(pptr_r[win], wctl[dcc_pkg::PW_LSB +: 2]);
  assign w_ma = align_fn(mptr_r[win], wctl[dcc_pkg::MW_LSB +: 2]);
  assign c_pa = align_fn(pptr_r[cur_r], cctl[dcc_pkg::PW_LSB +: 2]);
  assign c_ma = align_fn(mptr_r[cur_r], cctl[dcc_pkg::MW_LSB +: 2]);

  logic rd_ok;
  logic done;
  logic err_ev;
  assign rd_ok = (state_r == dcc_pkg::ST_READ) && bus_ready && !bus_err;
  assign done = (state_r == dcc_pkg::ST_WRITE) && bus_ready && !bus_err;
  assign err_ev = (state_r != dcc_pkg::ST_IDLE) && bus_ready && bus_err;

  // Sequencer: each transfer is one read from the source, then one write to the destination.
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      state_r <= dcc_pkg::ST_IDLE;
      cur_r <= '0;
      data_r <= '0;
      bus_addr_r <= '0;
      bus_we_r <= 1'b0;
      bus_size_r <= dcc_pkg::W8;
    end
    else
    begin
      case (state_r)
        dcc_pkg::ST_IDLE:
        begin
          if (found)
          begin
            cur_r <= win;
            state_r <= dcc_pkg::ST_READ;
            bus_we_r <= 1'b0;
            bus_addr_r <= wctl[dcc_pkg::DIR_BIT] ? w_ma : w_pa;
            bus_size_r <= wctl[dcc_pkg::DIR_BIT] ? wctl[dcc_pkg::MW_LSB +: 2]
                                                 : wctl[dcc_pkg::PW_LSB +: 2];
          end
        end
        dcc_pkg::ST_READ:
        begin
          if (err_ev)
          begin
            state_r <= dcc_pkg::ST_IDLE;
          end
          else if (rd_ok)
          begin
            data_r <= bus_rdata;
            state_r <= dcc_pkg::ST_WRITE;
            bus_we_r <= 1'b1;
            bus_addr_r <= cctl[dcc_pkg::DIR_BIT] ? c_pa : c_ma;
            bus_size_r <= cctl[dcc_pkg::DIR_BIT] ? cctl[dcc_pkg::PW_LSB +: 2]
                                                 : cctl[dcc_pkg::MW_LSB +: 2];
          end
        end
        dcc_pkg::ST_WRITE:
        begin
          if (bus_ready)
          begin
            state_r <= dcc_pkg::ST_IDLE;
            bus_we_r <= 1'b0;
          end
        end
        default:
        begin
          state_r <= dcc_pkg::ST_IDLE;
        end
      endcase
    end
  end

  assign bus_req = (state_r != dcc_pkg::ST_IDLE);
  assign bus_we = bus_we_r;
  assign bus_addr = bus_addr_r;
  assign bus_size = bus_size_r;
  assign bus_wdata = data_r;

  // Per-channel events of the finishing transfer.
  logic [NCH-1:0] full_ev;
  logic [NCH-1:0] half_ev;
  logic [NCH-1:0] fail_ev;
  logic [15:0] cnt_dec [NCH];
  always_comb
  begin
    for (int c = 0; c < NCH; c++)
    begin
      cnt_dec[c] = cnt_r[c] - 16'h0001;
      full_ev[c] = done && (cur_r == CW'(c)) && (cnt_dec[c] == 16'h0000);
      half_ev[c] = done && (cur_r == CW'(c)) && (cnt_dec[c] == (reload_r[c] >> 1));
      fail_ev[c] = err_ev && (cur_r == CW'(c));
      periph_ack[c] = done && (cur_r == CW'(c)) && !ctl_r[c][dcc_pkg::M2M_BIT];
    end
  end

  // Channel registers. Software writes come first, hardware effects override them.
  always_ff @(posedge clock)
  begin
    for (int c = 0; c < NCH; c++)
    begin
      if (srst)
      begin
        ctl_r[c] <= dcc_pkg::CTL_RST;
        cnt_r[c] <= dcc_pkg::CNT_RST;
        reload_r[c] <= dcc_pkg::CNT_RST;
        pbase_r[c] <= dcc_pkg::ADDR_RST;
        mbase_r[c] <= dcc_pkg::ADDR_RST;
        pptr_r[c] <= dcc_pkg::ADDR_RST;
        mptr_r[c] <= dcc_pkg::ADDR_RST;
      end
      else
      begin
        if (reg_wr && hit_ctl[c])
        begin
          // Interrupt enables and the enable bit stay writable while running.
          ctl_r[c] <= ctl_r[c][dcc_pkg::ON_BIT]
            ? ((ctl_r[c] & dcc_pkg::LOCK_MASK) | (reg_wdata[14:0] & ~dcc_pkg::LOCK_MASK))
            : reg_wdata[14:0];
          if (!ctl_r[c][dcc_pkg::ON_BIT] && reg_wdata[dcc_pkg::ON_BIT])
          begin
            pptr_r[c] <= pbase_r[c];
            mptr_r[c] <= mbase_r[c];
          end
        end
        if (!ctl_r[c][dcc_pkg::ON_BIT])
        begin
          if (reg_wr && hit_cnt[c])
          begin
            cnt_r[c] <= reg_wdata[15:0];
            reload_r[c] <= reg_wdata[15:0];
          end
          if (reg_wr && hit_pb[c])
          begin
            pbase_r[c] <= reg_wdata;
          end
          if (reg_wr && hit_mb[c])
          begin
            mbase_r[c] <= reg_wdata;
          end
        end
        if (done && cur_r == CW'(c))
        begin
          cnt_r[c] <= cnt_dec[c];
          if (ctl_r[c][dcc_pkg::PINC_BIT])
          begin
            pptr_r[c] <= pptr_r[c] + step_fn(ctl_r[c][dcc_pkg::PW_LSB +: 2]);
          end
          if (ctl_r[c][dcc_pkg::MINC_BIT])
          begin
            mptr_r[c] <= mptr_r[c] + step_fn(ctl_r[c][dcc_pkg::MW_LSB +: 2]);
          end
          if (full_ev[c] && ctl_r[c][dcc_pkg::CIRC_BIT])
          begin
            cnt_r[c] <= reload_r[c];
            pptr_r[c] <= pbase_r[c];
            mptr_r[c] <= mbase_r[c];
          end
        end
        if (fail_ev[c])
        begin
          ctl_r[c][dcc_pkg::ON_BIT] <= 1'b0;
        end
      end
    end
  end

  // Sticky event flags; a hardware set wins over a clear in the same cycle.
  always_ff @(posedge clock)
  begin
    for (int c = 0; c < NCH; c++)
    begin
      if (srst)
      begin
        flags_r[3*c +: 3] <= 3'b000;
      end
      else
      begin
        flags_r[3*c +: 3] <= (flags_r[3*c +: 3]
          & ~((reg_wr && reg_addr == dcc_pkg::CLR_OFS) ? reg_wdata[3*c +: 3] : 3'b000))
          | {fail_ev[c], half_ev[c], full_ev[c]};
      end
    end
  end

  // Interrupt pulses, each event gated by its own enable.
  always_ff @(posedge clock)
  begin
    for (int c = 0; c < NCH; c++)
    begin
      if (srst)
      begin
        irq_r[c] <= 1'b0;
      end
      else
      begin
        irq_r[c] <= (fail_ev[c] && ctl_r[c][dcc_pkg::ERIE_BIT])
          || (half_ev[c] && ctl_r[c][dcc_pkg::HTIE_BIT])
          || (full_ev[c] && ctl_r[c][dcc_pkg::FTIE_BIT]);
      end
    end
  end
  assign irq = irq_r;

  // Read data in the cycle after the strobe; unmapped offsets read zero.
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      reg_rdata_r <= '0;
    end
    else
    begin
      reg_rdata_r <= '0;
      if (reg_rd)
      begin
        if (reg_addr == dcc_pkg::FLAG_OFS)
        begin
          reg_rdata_r <= 32'(flags_r);
        end
        for (int c = 0; c < NCH; c++)
        begin
          if (hit_ctl[c])
          begin
            reg_rdata_r <= {17'h0, ctl_r[c]};
          end
          if (hit_cnt[c])
          begin
            reg_rdata_r <= {16'h0, cnt_r[c]};
          end
          if (hit_pb[c])
          begin
            reg_rdata_r <= pbase_r[c];
          end
          if (hit_mb[c])
          begin
            reg_rdata_r <= mbase_r[c];
          end
        end
      end
    end
  end
  assign reg_rdata = reg_rdata_r;

  // Checks on the sequencer and channel 0.
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  logic mem_phase;
  assign mem_phase = (state_r == dcc_pkg::ST_READ) == cctl[dcc_pkg::DIR_BIT];

  a_zero_no_bus: assert property ($rose(bus_req) |-> cnt_r[cur_r] != 16'h0000)
    else $error("Bus started for a channel with zero count.");
  a_count_step: assert property (done && cur_r == '0 && !full_ev[0]
    |=> cnt_r[0] == $past(cnt_r[0]) - 16'h0001)
    else $error("Counter did not decrement by one.");
  a_circ_reload: assert property (full_ev[0] && ctl_r[0][dcc_pkg::CIRC_BIT]
    |=> cnt_r[0] == reload_r[0])
    else $error("Circular counter not reloaded.");
  a_lock_fields: assert property (ctl_r[0][dcc_pkg::ON_BIT] && reg_wr
    |=> (ctl_r[0] & dcc_pkg::LOCK_MASK) == ($past(ctl_r[0]) & dcc_pkg::LOCK_MASK))
    else $error("Locked field changed while enabled.");
  a_err_stops: assert property (fail_ev[0] |=> !ctl_r[0][dcc_pkg::ON_BIT] ##0 flags_r[dcc_pkg::FL_ERR])
    else $error("Bus error did not stop the channel.");
  a_full_irq: assert property (full_ev[0] |=> irq[0] == ($past(ctl_r[0][dcc_pkg::FTIE_BIT])
    || $past(half_ev[0] && ctl_r[0][dcc_pkg::HTIE_BIT])))
    else $error("Full-done interrupt not gated by its enable.");
  a_mem_align: assert property (bus_req && mem_phase && cctl[dcc_pkg::MW_LSB +: 2] == dcc_pkg::W32
    |-> bus_addr[1:0] == 2'b00)
    else $error("Memory word access misaligned.");
  a_periph_align: assert property (bus_req && !mem_phase && cctl[dcc_pkg::PW_LSB +: 2] == dcc_pkg::W16
    |-> bus_addr[0] == 1'b0)
    else $error("Peripheral halfword access misaligned.");
  a_fixed_mem: assert property (done && cur_r == '0 && !ctl_r[0][dcc_pkg::MINC_BIT] && !full_ev[0]
    |=> $stable(mptr_r[0]))
    else $error("Fixed memory address moved.");
endmodule

// File: hw/dcc_pkg.sv
// Shared constants for the DMA channel configuration and counting block.
// Function
// - Memory-to-memory select bit set runs the channel memory to memory.
// - Priority codes 00 low, 01 medium, 10 high, 11 ultra high.
// - Memory width codes 00, 01, 10 give 8, 16, 32 bits.
// - Peripheral width codes 00, 01, 10 give 8, 16, 32 bits.
// - Memory address stays fixed or increases per transfer by its increment bit.
// - Peripheral address stays fixed or increases per transfer by its increment bit.
// - Circular enable bit turns circular operation on or off.
// - Direction 0 reads peripheral writes memory; 1 reads memory writes peripheral.
// - Error interrupt requested only while its enable bit is set.
// - Half-done interrupt requested only while its enable bit is set.
// - Full-done interrupt requested only while its enable bit is set.
// - While enabled, mode fields, counter and base addresses ignore writes.
// - Sixteen-bit counter is read-only when enabled, decrements per transfer.
// - A zero counter issues no bus transaction whatever the enable.
// - Circular mode reloads the counter with the last programmed value.
// - Peripheral address drops one or two low bits for 16 or 32 bits.
// - Memory address drops one or two low bits for 16 or 32 bits.
// - Memory-to-memory starts on enable without request, ends at zero count.
// - Channel interrupt fires on any enabled full, half or error event.
package dcc_pkg;
  // Register offsets; channel registers repeat every stride.
  localparam logic [7:0] FLAG_OFS = 8'h00;
  localparam logic [7:0] CLR_OFS = 8'h04;
  localparam logic [7:0] CTL_OFS = 8'h08;
  localparam logic [7:0] CNT_OFS = 8'h0c;
  localparam logic [7:0] PBASE_OFS = 8'h10;
  localparam logic [7:0] MBASE_OFS = 8'h14;
  localparam logic [7:0] CH_STRIDE = 8'h14;
  // Control field positions.
  localparam int ON_BIT = 0;
  localparam int FTIE_BIT = 1;
  localparam int HTIE_BIT = 2;
  localparam int ERIE_BIT = 3;
  localparam int DIR_BIT = 4;
  localparam int CIRC_BIT = 5;
  localparam int PINC_BIT = 6;
  localparam int MINC_BIT = 7;
  localparam int PW_LSB = 8;
  localparam int MW_LSB = 10;
  localparam int CHAN_PRIORITY_LSB = 12;
  localparam int M2M_BIT = 14;
  // Fields frozen while the channel is on.
  localparam logic [14:0] LOCK_MASK = 15'h7ff0;
  // Flag layout, three bits per channel.
  localparam int FL_FULL = 0;
  localparam int FL_HALF = 1;
  localparam int FL_ERR = 2;
  // Reset values.
  localparam logic [14:0] CTL_RST = 15'h0000;
  localparam logic [15:0] CNT_RST = 16'h0000;
  localparam logic [31:0] ADDR_RST = 32'h0000_0000;
  // Width codes.
  localparam logic [1:0] W8 = 2'b00;
  localparam logic [1:0] W16 = 2'b01;
  localparam logic [1:0] W32 = 2'b10;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_READ = 2'b01,
    ST_WRITE = 2'b10
  } dcc_state_t;
endpackage

// File: verif/dcc_bus_model.sv
// Behavioural system bus memory that answers the channel block's master port.
module dcc_bus_model (
  // Clock and reset.
  input wire logic clock,
  input wire logic srst,
  // Bus from the channel block.
  input wire logic bus_req,
  input wire logic bus_we,
  input wire logic [31:0] bus_addr,
  input wire logic [31:0] bus_wdata,
  output logic bus_ready,
  output logic bus_err,
  output logic [31:0] bus_rdata,
  // Test controls and transfer log.
  input wire logic [3:0] dly,
  input wire logic err_inj,
  output logic [31:0] raddr_r,
  output logic [31:0] waddr_r,
  output logic [31:0] wdata_r,
  output logic [15:0] wcnt_r
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] KEY = 32'h5a5a_0000;
  logic rdy_r;
  logic err_r;
  logic [3:0] wait_r;
  logic [31:0] rdq_r;

  // Each phase waits dly cycles; read data is the address scrambled so a lost word shows.
  // Between answers the data lines show the inverse of the last word, never a stale copy.
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      rdy_r <= 1'b0;
      err_r <= 1'b0;
      wait_r <= 4'h0;
      rdq_r <= 32'h0000_0000;
    end
    else if (rdy_r)
    begin
      rdy_r <= 1'b0;
      err_r <= 1'b0;
      wait_r <= 4'h0;
      rdq_r <= ~rdq_r;
    end
    else if (bus_req && wait_r == dly)
    begin
      rdy_r <= 1'b1;
      err_r <= err_inj;
      rdq_r <= bus_addr ^ KEY;
    end
    else if (bus_req)
      wait_r <= wait_r + 4'h1;
  end

  // Log every completed phase for the bench to compare.
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      raddr_r <= 32'h0000_0000;
      waddr_r <= 32'h0000_0000;
      wdata_r <= 32'h0000_0000;
      wcnt_r <= 16'h0000;
    end
    else if (bus_req && rdy_r && bus_we)
    begin
      waddr_r <= bus_addr;
      wdata_r <= bus_wdata;
      wcnt_r <= wcnt_r + 16'h0001;
    end
    else if (bus_req && rdy_r)
      raddr_r <= bus_addr;
  end

  // Outputs come straight from the answer registers.
  assign bus_ready = rdy_r;
  assign bus_err = err_r;
  assign bus_rdata = rdq_r;
endmodule

// File: verif/tb_dcc_channels.sv
// Self-checking bench for the DMA channel block with two channels.
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin err_total++; \
  $display("unexpected %s exp %h got %h", n, e, g); end end
module tb_dcc_channels;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] KEY = 32'h5a5a_0000;
  logic clock = 1'b0;
  logic srst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic [1:0] periph_req = 2'b00;
  logic [1:0] periph_ack;
  logic [1:0] irq;
  logic bus_req, bus_we, bus_ready, bus_err;
  logic [1:0] bus_size;
  logic [31:0] bus_addr, bus_wdata, bus_rdata, raddr, waddr, wdata;
  logic [15:0] wcnt;
  logic [3:0] dly = 4'h0;
  logic err_inj = 1'b0;
  logic [1:0] la, rsz, wsz;
  logic [31:0] d, cfg;
  int err_total = 0;
  int samples_checked = 0;
  int n_ack = 0;
  int n_irq[2] = '{0, 0};
  int i0, w0, k;

  dcc_channels #(.NCH(2)) i_dcc_channels (.clock(clock), .srst(srst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .periph_req(periph_req), .periph_ack(periph_ack), .bus_req(bus_req), .bus_we(bus_we),
    .bus_addr(bus_addr), .bus_size(bus_size), .bus_wdata(bus_wdata), .bus_ready(bus_ready),
    .bus_err(bus_err), .bus_rdata(bus_rdata), .irq(irq));
  dcc_bus_model i_dcc_bus_model (.clock(clock), .srst(srst), .bus_req(bus_req), .bus_we(bus_we),
    .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_ready(bus_ready), .bus_err(bus_err),
    .bus_rdata(bus_rdata), .dly(dly), .err_inj(err_inj), .raddr_r(raddr), .waddr_r(waddr),
    .wdata_r(wdata), .wcnt_r(wcnt));

  // Clock of 4 ns.
  always #2 clock = ~clock;

  // Count acknowledges and interrupt pulses as they stand at each edge.
  always @(posedge clock)
  begin
    n_ack += (periph_ack != 2'b00);
    n_irq[0] += irq[0];
    n_irq[1] += irq[1];
  end

  // Width codes of the last completed read and write phases, so the size lines are checked too.
  always @(posedge clock)
  begin
    if (bus_req && bus_ready && bus_we)
      wsz <= bus_size;
    else if (bus_req && bus_ready)
      rsz <= bus_size;
  end

  // Register offset of a channel register.
  function automatic logic [7:0] ra(int ch, logic [7:0] ofs);
    return ofs + 8'(ch * 20);
  endfunction

  // Control word: m2m, priority, widths, increments, circular, direction, enables, on.
  function automatic logic [31:0] cw(logic m2m, logic [1:0] pr, logic [1:0] mw, logic [1:0] pw,
    logic minc, logic pinc, logic circ, logic dir, logic [2:0] ie, logic on);
    return {17'h0, m2m, pr, mw, pw, minc, pinc, circ, dir, ie, on};
  endfunction

  function automatic logic cond(int c);
    return c == 2 ? (bus_ready & bus_err) : c == 3 ? |periph_ack : periph_ack[c];
  endfunction

  // Whole-word accesses only, so base registers are never written in part.
  task automatic wr(logic [7:0] a, logic [31:0] v);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(logic [7:0] a);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  // Wait at falling edges, where outputs are settled, for a bounded time.
  // The launching edge is let pass first, so an acknowledge still standing from the last transfer is not taken again.
  task automatic wt(int c);
    @(negedge clock);
    for (int n = 0; n < 200 && !cond(c); n++)
      @(negedge clock);
    if (cond(c) !== 1'b1)
      err_total++;
    la = periph_ack;
  endtask

  // One requested transfer: hold the request until its acknowledge.
  task automatic one_xfer(int ch);
    @(posedge clock);
    periph_req[ch] <= 1'b1;
    wt(ch);
    @(posedge clock);
    periph_req[ch] <= 1'b0;
    #1;
  endtask

  task automatic arb(logic [1:0] p0, logic [1:0] p1, logic [1:0] e);
    for (int c = 0; c < 2; c++)
    begin
      wr(ra(c, dcc_pkg::CTL_OFS), 32'h0);
      wr(ra(c, dcc_pkg::CNT_OFS), 32'h2);
      wr(ra(c, dcc_pkg::CTL_OFS), cw(0, c ? p1 : p0, 2'b10, 2'b10, 0, 0, 0, 0, 3'b000, 1));
    end
    @(posedge clock);
    periph_req <= 2'b11;
    wt(3);
    `CHK("grant", e, la)
    @(posedge clock);
    periph_req <= ~e;
    wt(3);
    @(posedge clock);
    periph_req <= 2'b00;
  endtask

  task automatic stop_test();
    if (err_total == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Watchdog: the sequence needs a few hundred cycles.
  initial
  begin
    #80000;
    err_total++;
    stop_test();
  end

  // Main sequence.
  initial
  begin
    repeat (20) @(posedge clock);
    srst <= 1'b0;
    for (int i = 0; i < 4; i++)
    begin
      rd(ra(1, 8'(8 + 4 * i)));
      `CHK("reset value", 32'h0, d)
    end
    rd(8'hfc);
    `CHK("unmapped", 32'h0, d)
    // Peripheral to memory, word periph fixed, halfword memory rising.
    wr(ra(0, dcc_pkg::PBASE_OFS), 32'h1000_0003);
    wr(ra(0, dcc_pkg::MBASE_OFS), 32'h2000_0003);
    wr(ra(0, dcc_pkg::CNT_OFS), 32'h3);
    cfg = cw(0, 2'b00, 2'b01, 2'b10, 1, 0, 0, 0, 3'b011, 1);
    wr(ra(0, dcc_pkg::CTL_OFS), cfg);
    for (k = 0; k < 3; k++)
    begin
      if (k == 2)
      begin
        wr(ra(0, dcc_pkg::CNT_OFS), 32'h55);
        wr(ra(0, dcc_pkg::CTL_OFS), cfg ^ 32'h7ff0);
      end
      one_xfer(0);
      `CHK("rd addr", 32'h1000_0000, raddr)
      `CHK("wr addr", 32'h2000_0002 + 2 * k, waddr)
      `CHK("wr data", 32'h1000_0000 ^ KEY, wdata)
      `CHK("rd size", 2'b10, rsz)
      `CHK("wr size", 2'b01, wsz)
      rd(ra(0, dcc_pkg::CNT_OFS));
      `CHK("count", 32'(2 - k), d)
    end
    rd(ra(0, dcc_pkg::CTL_OFS));
    `CHK("control", cfg, d)
    `CHK("irq0", 2, n_irq[0])
    // Memory to memory on channel 1, bytes both sides, slow bus, no enables.
    dly <= 4'h3;
    w0 = wcnt;
    i0 = n_ack;
    wr(ra(1, dcc_pkg::PBASE_OFS), 32'h3000_0000);
    wr(ra(1, dcc_pkg::MBASE_OFS), 32'h4000_0000);
    wr(ra(1, dcc_pkg::CNT_OFS), 32'h2);
    wr(ra(1, dcc_pkg::CTL_OFS), cw(1, 2'b00, 2'b00, 2'b00, 1, 1, 0, 1, 3'b000, 1));
    for (int n = 0; n < 400 && wcnt != w0 + 2; n++)
      @(negedge clock);
    `CHK("m2m rd", 32'h4000_0001, raddr)
    `CHK("m2m wr", 32'h3000_0001, waddr)
    `CHK("m2m ack", i0, n_ack)
    `CHK("irq1", 0, n_irq[1])
    repeat (30) @(posedge clock);
    `CHK("idle at zero", w0 + 16'd2, wcnt)
    rd(dcc_pkg::FLAG_OFS);
    `CHK("flags", 32'h1b, d)
    wr(dcc_pkg::CLR_OFS, 32'h3f);
    rd(dcc_pkg::FLAG_OFS);
    `CHK("flags clear", 32'h0, d)
    dly <= 4'h0;
    arb(2'b00, 2'b10, 2'b10);
    arb(2'b01, 2'b01, 2'b01);
    arb(2'b11, 2'b10, 2'b01);
    // Circular on channel 0, then a bus error.
    wr(ra(0, dcc_pkg::CTL_OFS), 32'h0);
    wr(ra(0, dcc_pkg::CNT_OFS), 32'h2);
    wr(ra(0, dcc_pkg::CTL_OFS), cw(0, 2'b00, 2'b10, 2'b01, 1, 0, 1, 0, 3'b101, 1));
    i0 = n_irq[0];
    for (k = 0; k < 3; k++)
    begin
      one_xfer(0);
      `CHK("circ addr", k == 1 ? 32'h2000_0004 : 32'h2000_0000, waddr)
      `CHK("circ rd", 32'h1000_0002, raddr)
    end
    `CHK("circ irq", i0 + 1, n_irq[0])
    @(posedge clock);
    err_inj <= 1'b1;
    periph_req[0] <= 1'b1;
    wt(2);
    @(posedge clock);
    periph_req[0] <= 1'b0;
    err_inj <= 1'b0;
    rd(ra(0, dcc_pkg::CTL_OFS));
    `CHK("err on bit", 1'b0, d[0])
    rd(ra(0, dcc_pkg::CNT_OFS));
    `CHK("err count", 32'h1, d)
    rd(dcc_pkg::FLAG_OFS);
    `CHK("err flag", 1'b1, d[2])
    `CHK("err irq", i0 + 2, n_irq[0])
    stop_test();
  end
endmodule
